/* File: src/trc_device.sv */
// device end: reset sequencing, reset mode, afc status report
//
// How it works
// RULE1: after reset, glitch detection on, sensitive mode
// RULE2: normal mode disables glitch-triggered resets
// RULE3: fifo/reset command bit0 selects normal mode
// RULE4: every reset reloads power-on register values
// RULE5: reset pin low at least 1us resets
// RULE6: ready 1ms after reset pin released
// RULE7: command FE00h triggers software reset
// RULE8: software reset behaves like power-on reset
// RULE9: host avoids soft reset when pins share
// RULE10: status read returns measured afc offset
// RULE11: host clears afc enable before status read
// RULE12: commands ignored during power-on reset, 150ms
// RULE13: internal reset held while pin low
`timescale 1ns/1ps
module trc_device #(
	parameter int unsigned POR_CYCLES   = trc_pkg::POR_CYC,
	parameter int unsigned READY_CYCLES = trc_pkg::READY_CYC
) (
	input  wire logic                              clk_sys,
	input  wire logic                              nrst,
	trc_if.dev                                     lnk,
	input  wire logic                              vdd_glitch,
	input  wire logic [trc_pkg::AFC_OFFS_W-1:0]    afc_offset,
	output logic                                   glitch_det_en,
	output logic                                   afc_en,
	output logic                                   dev_ready,
	output logic                                   reset_active
);
	import trc_pkg::*;

	// synchronised copies of the two inputs from outside this clock
	logic [2:0]             pin_sync_ff;
	logic                   pin_ff;
	logic [2:0]             glitch_sync_ff;
	logic                   glitch_ff;
	// sequencer
	trc_state_t             state_ff;
	logic [CNT_W-1:0]       cnt_ff;
	logic                   por_done_ff;
	// state the host can change by command
	logic                   normal_mode_ff;
	logic [7:0]             afc_ctrl_ff;
	// answer path
	logic                   rsp_valid_ff;
	logic [15:0]            rsp_data_ff;
	// decoded this cycle
	logic                   cmd_take;
	logic                   sw_reset;
	logic                   glitch_reset;
	logic                   wait_done;

	// true when a word carries the given command high byte
	function automatic logic cmd_sel(input logic [15:0] word, input logic [7:0] hi);
		return word[15:8] == hi;
	endfunction

	// status read is a full-word match
	function automatic logic is_status(input logic [15:0] word);
		return word == CMD_STATUS;
	endfunction

	// terminal count of a recovery wait of the given length
	function automatic logic cnt_end(input logic [CNT_W-1:0] cnt, input int unsigned len);
		return cnt == CNT_W'(len - 1);
	endfunction

	// pin crosses in from the host: three stages, change counts when last two agree
	// resets to low so the core stays held until the host lets go
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pin_sync_ff <= 3'h0;
			pin_ff      <= 1'b0;
		end else begin
			pin_sync_ff <= {pin_sync_ff[1:0], lnk.hw_reset_in_n};
			if (pin_sync_ff[1] == pin_sync_ff[2])
				pin_ff <= pin_sync_ff[2];
		end
	end

	// supply glitch flag comes from the analog monitor, outside this clock
	// single-cycle spikes are filtered; the monitor must hold it two cycles or more
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			glitch_sync_ff <= 3'h0;
			glitch_ff      <= 1'b0;
		end else begin
			glitch_sync_ff <= {glitch_sync_ff[1:0], vdd_glitch};
			if (glitch_sync_ff[1] == glitch_sync_ff[2])
				glitch_ff <= glitch_sync_ff[2];
		end
	end

	assign cmd_take     = lnk.cmd_valid && lnk.cmd_ready;
	assign sw_reset     = cmd_take && (lnk.cmd_data == CMD_SW_RESET); // see RULE7
	// glitch resets only reach the core in sensitive mode
	assign glitch_reset = glitch_ff && !normal_mode_ff; // see RULE2
	// the first release after power-up, and any soft reset, waits the long time
	assign wait_done    = por_done_ff ? cnt_end(cnt_ff, READY_CYCLES) // see RULE6
	                                  : cnt_end(cnt_ff, POR_CYCLES);  // see RULE12

	// reset sequencer: hold while the pin is low, then wait out the recovery
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_ff <= TRC_RST;
		end else begin
			case (state_ff)
				TRC_RST: begin
					if (pin_ff) // see RULE13
						state_ff <= TRC_WAIT;
				end
				TRC_WAIT: begin
					// a new reset source during the wait starts it over
					if (!pin_ff || glitch_reset) // see RULE5
						state_ff <= TRC_RST;
					else if (wait_done)
						state_ff <= TRC_RUN; // see RULE6
				end
				TRC_RUN: begin
					// soft reset drops to the same hold state as the pin
					if (!pin_ff || glitch_reset || sw_reset) // see RULE8
						state_ff <= TRC_RST;
				end
				// an illegal code falls back to hold
				default: state_ff <= TRC_RST;
			endcase
		end
	end

	// recovery counter: cleared outside the wait, counts up to the terminal value
	// wide enough for the long power-on wait at the full clock rate
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= '0;
		end else if (state_ff != TRC_WAIT) begin
			cnt_ff <= '0;
		end else if (!wait_done) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	// power-on flag: set when the long wait ends, cleared by a soft reset
	// pin and glitch resets keep it, so those recover in the short time
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			por_done_ff <= 1'b0;
		end else if (sw_reset) begin
			por_done_ff <= 1'b0; // see RULE8
		end else if (state_ff == TRC_WAIT && pin_ff && !glitch_reset && wait_done) begin
			por_done_ff <= 1'b1; // see RULE12
		end
	end

	// reset mode: every reset reloads sensitive, only the fifo/reset command leaves it
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			normal_mode_ff <= 1'b0; // see RULE1
		end else if (state_ff != TRC_RUN) begin
			normal_mode_ff <= 1'b0; // see RULE4
		end else if (cmd_take && cmd_sel(lnk.cmd_data, CMD_FIFO_RST_HI)) begin
			if (lnk.cmd_data[FIFO_RST_MODE_BIT])
				normal_mode_ff <= 1'b1; // see RULE3
		end
	end

	// afc control byte: power-on value on any reset, rewritten whole by the afc command
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			afc_ctrl_ff <= AFC_CTRL_RST;
		end else if (state_ff != TRC_RUN) begin
			afc_ctrl_ff <= AFC_CTRL_RST; // see RULE4
		end else if (cmd_take && cmd_sel(lnk.cmd_data, CMD_AFC_HI)) begin
			afc_ctrl_ff <= lnk.cmd_data[7:0];
		end
	end

	// status answer: one-cycle pulse the cycle after a taken status command
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rsp_valid_ff <= 1'b0;
		end else begin
			rsp_valid_ff <= cmd_take && is_status(lnk.cmd_data); // see RULE10
		end
	end

	// offset captured at the take and held until the next status read
	// a host that froze the afc first therefore reads a settled value
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rsp_data_ff <= 16'h0000;
		end else if (cmd_take && is_status(lnk.cmd_data)) begin
			rsp_data_ff <= {{(16 - AFC_OFFS_W){1'b0}}, afc_offset}; // see RULE10
		end
	end

	// link side: commands refused outside run; host sees ready low
	assign lnk.cmd_ready = (state_ff == TRC_RUN); // see RULE12
	assign lnk.rsp_valid = rsp_valid_ff;
	assign lnk.rsp_data  = rsp_data_ff;

	// status for the rest of the chip; glitch detection is live in sensitive mode
	assign glitch_det_en = !normal_mode_ff; // see RULE1
	assign afc_en        = afc_ctrl_ff[AFC_EN_BIT];
	assign dev_ready     = (state_ff == TRC_RUN);
	assign reset_active  = (state_ff == TRC_RST);
endmodule // trc_device

/* File: src/trc_pkg.sv */
// shared constants and types for the transceiver reset control link
package trc_pkg;
	localparam int unsigned CLK_HZ = 40000000;
	// least hardware reset pulse, ns, rounded up to whole cycles
	localparam int unsigned HW_RST_MIN_NS = 1000;
	localparam int unsigned HW_RST_MIN_CYC = (HW_RST_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
	// recovery after reset release, us
	localparam int unsigned READY_US = 1000;
	localparam int unsigned READY_CYC = READY_US * (CLK_HZ / 1000000);
	// longest power-on reset, ms
	localparam int unsigned POR_MS = 150;
	localparam int unsigned POR_CYC = POR_MS * (CLK_HZ / 1000);
	localparam logic [15:0] CMD_SW_RESET = 16'hfe00;
	// fifo and reset-mode command: upper byte selects it, bit 0 picks normal mode
	localparam logic [7:0] CMD_FIFO_RST_HI = 8'hca;
	localparam int unsigned FIFO_RST_MODE_BIT = 0;
	// afc command: upper byte selects it, bit 0 enables afc
	localparam logic [7:0] CMD_AFC_HI = 8'hc4;
	localparam int unsigned AFC_EN_BIT = 0;
	// status read command
	localparam logic [15:0] CMD_STATUS = 16'h0000;
	localparam int unsigned AFC_OFFS_W = 7;
	localparam logic [7:0] AFC_CTRL_RST = 8'hf7;
	localparam int unsigned CNT_W = 23;
	typedef enum logic [2:0] {
		TRC_RST  = 3'b001,
		TRC_WAIT = 3'b010,
		TRC_RUN  = 3'b100
	} trc_state_t;
endpackage

/* File: src/trc_if.sv */
// link between host and transceiver reset control
`timescale 1ns/1ps
interface trc_if;
	logic        hw_reset_in_n;
	logic        cmd_valid;
	logic [15:0] cmd_data;
	logic        cmd_ready;
	logic        rsp_valid;
	logic [15:0] rsp_data;
	modport dev  (input hw_reset_in_n, input cmd_valid, input cmd_data,
		output cmd_ready, output rsp_valid, output rsp_data);
	modport host (output hw_reset_in_n, output cmd_valid, output cmd_data,
		input cmd_ready, input rsp_valid, input rsp_data);
endinterface

/* File: src/trc_host.sv */
// host end: drives reset pin, issues commands, reads afc offset
`timescale 1ns/1ps
module trc_host (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	trc_if.host              lnk,
	input  wire logic        req_hw_reset,
	input  wire logic        req_valid,
	input  wire logic [15:0] req_data,
	output logic             req_ready,
	input  wire logic        req_read_afc,
	output logic             afc_valid,
	output logic [6:0]       afc_value,
	output logic             busy
);
	import trc_pkg::*;

	typedef enum logic [3:0] {
		TRH_IDLE = 4'b0001,
		TRH_PULSE = 4'b0010,
		TRH_AFCOFF = 4'b0100,
		TRH_STAT = 4'b1000
	} trc_hstate_t;

	trc_hstate_t      state_ff;
	logic [7:0]       pcnt_ff;
	logic             pin_ff;
	logic             afc_valid_ff;
	logic [6:0]       afc_value_ff;

	// pulse length kept at the least time plus margin, see RULE5
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_ff <= TRH_IDLE;
			pcnt_ff  <= 8'h00;
			pin_ff   <= 1'b0;
		end else begin
			case (state_ff)
				TRH_IDLE: begin
					pin_ff <= 1'b1;
					if (req_hw_reset) begin
						state_ff <= TRH_PULSE;
						pin_ff   <= 1'b0;
						pcnt_ff  <= 8'h00;
					end else if (req_read_afc && lnk.cmd_ready) begin
						state_ff <= TRH_AFCOFF;
					end
				end
				TRH_PULSE: begin
					pcnt_ff <= pcnt_ff + 8'h01;
					if (pcnt_ff == 8'(HW_RST_MIN_CYC)) begin
						state_ff <= TRH_IDLE;
						pin_ff   <= 1'b1;
					end
				end
				// afc off first so the offset is stable
				TRH_AFCOFF: if (lnk.cmd_ready) state_ff <= TRH_STAT; // see RULE11
				TRH_STAT: if (lnk.cmd_ready) state_ff <= TRH_IDLE;
				default: state_ff <= TRH_IDLE;
			endcase
		end
	end

	// catch the status answer
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			afc_valid_ff <= 1'b0;
			afc_value_ff <= 7'h00;
		end else begin
			afc_valid_ff <= lnk.rsp_valid;
			if (lnk.rsp_valid)
				afc_value_ff <= lnk.rsp_data[6:0];
		end
	end

	// user commands pass straight through while idle; no buffering
	always_comb begin
		lnk.cmd_valid = 1'b0;
		lnk.cmd_data  = 16'h0000;
		case (state_ff)
			TRH_AFCOFF: begin
				lnk.cmd_valid = 1'b1;
				lnk.cmd_data  = {CMD_AFC_HI, AFC_CTRL_RST & ~8'h01};
			end
			TRH_STAT: begin
				lnk.cmd_valid = 1'b1;
				lnk.cmd_data  = CMD_STATUS;
			end
			TRH_IDLE: begin
				lnk.cmd_valid = req_valid && !req_hw_reset && !req_read_afc;
				lnk.cmd_data  = req_data;
			end
			default: ;
		endcase
	end

	assign lnk.hw_reset_in_n = pin_ff;
	assign req_ready = (state_ff == TRH_IDLE) && !req_hw_reset && !req_read_afc && lnk.cmd_ready;
	assign afc_valid = afc_valid_ff;
	assign afc_value = afc_value_ff;
	assign busy      = (state_ff != TRH_IDLE);
endmodule // trc_host

/* File: testbench/trc_assertions.sv */
// concurrent checks on the link between host and device ends
`timescale 1ns/1ps
module trc_assertions #(
	parameter int unsigned POR_CYCLES   = 50,
	parameter int unsigned READY_CYCLES = 20
) (
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic        hw_reset_in_n,
	input wire logic        cmd_valid,
	input wire logic [15:0] cmd_data,
	input wire logic        cmd_ready,
	input wire logic        rsp_valid,
	input wire logic [15:0] rsp_data
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// release-to-ready window: short recovery at least, power-on wait plus sync at most
	localparam int RDY_LO = READY_CYCLES;
	localparam int RDY_HI = POR_CYCLES + 30;
	// a command word handed over this cycle
	wire take = cmd_valid && cmd_ready;
	sw_reset_drop_a: assert property (take && cmd_data == 16'hfe00 |=> !cmd_ready[*8])
		else $error("ready stayed up after soft reset");
	pin_low_a: assert property ($fell(hw_reset_in_n) |-> ##[1:5] !cmd_ready)
		else $error("ready stayed up after pin fell");
	pin_hold_a: assert property (!hw_reset_in_n [*6] |-> !cmd_ready)
		else $error("ready while pin held low");
	status_answer_a: assert property (take && cmd_data == 16'h0000 |=> rsp_valid)
		else $error("no answer to status read");
	rsp_cause_a: assert property (rsp_valid |-> $past(take && cmd_data == 16'h0000))
		else $error("answer without status read");
	rsp_width_a: assert property (rsp_valid |-> rsp_data[15:7] == 9'h000)
		else $error("status word upper bits set");
	early_ready_a: assert property ($rose(hw_reset_in_n) |-> !cmd_ready[*8])
		else $error("ready too soon after release");
	ready_by_a: assert property ($rose(hw_reset_in_n) |-> ##[RDY_LO:RDY_HI] cmd_ready)
		else $error("ready late after release");
endmodule // trc_assertions

/* File: testbench/tb.sv */
// self-checking bench joining host and device ends
`timescale 1ns/1ps
module tb;
	import trc_pkg::*;
	localparam int unsigned POR_T = 50;
	localparam int unsigned RDY_T = 20;
	logic        clk_sys = 1'b0;
	logic        nrst = 1'b0;
	logic        req_hw_reset = 1'b0;
	logic        req_valid = 1'b0;
	logic [15:0] req_data = 16'h0000;
	logic        req_read_afc = 1'b0;
	logic        vdd_glitch = 1'b0;
	logic [6:0]  afc_offset = 7'h2b;
	logic        glitch_det_en, afc_en, dev_ready, reset_active, req_ready, afc_valid, busy;
	logic [6:0]  afc_value;
	int          errors = 0;
	int          checks_done = 0;
	int          cycles = 0;
	trc_if lnk ();
	trc_device #(.POR_CYCLES(POR_T), .READY_CYCLES(RDY_T)) trc_device_inst (.clk_sys(clk_sys),
		.nrst(nrst), .lnk(lnk), .vdd_glitch(vdd_glitch), .afc_offset(afc_offset),
		.glitch_det_en(glitch_det_en), .afc_en(afc_en), .dev_ready(dev_ready),
		.reset_active(reset_active));
	trc_host trc_host_inst (.clk_sys(clk_sys), .nrst(nrst), .lnk(lnk),
		.req_hw_reset(req_hw_reset), .req_valid(req_valid), .req_data(req_data),
		.req_ready(req_ready), .req_read_afc(req_read_afc), .afc_valid(afc_valid),
		.afc_value(afc_value), .busy(busy));
	trc_assertions #(.POR_CYCLES(POR_T), .READY_CYCLES(RDY_T)) trc_assertions_inst (
		.clk_sys(clk_sys), .nrst(nrst), .hw_reset_in_n(lnk.hw_reset_in_n),
		.cmd_valid(lnk.cmd_valid), .cmd_data(lnk.cmd_data), .cmd_ready(lnk.cmd_ready),
		.rsp_valid(lnk.rsp_valid), .rsp_data(lnk.rsp_data));
	// 40 mhz system clock
	always #12.5 clk_sys = ~clk_sys;
	// hang guard: whole run is well under a thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			results();
		end
	end
	task results;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// inputs always change one ns after the rising edge
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task send(input logic [15:0] d);
		req_valid = 1'b1;
		req_data = d;
		do @(negedge clk_sys); while (req_ready !== 1'b1);
		tick(1);
		req_valid = 1'b0;
	endtask
	// lets ready drop first, then counts cycles until it is back
	task wait_ready(input int lo, input int hi);
		int n;
		for (n = 0; dev_ready === 1'b1 && n < 8; n++) @(negedge clk_sys);
		for (n = 0; dev_ready !== 1'b1 && n <= hi; n++) @(negedge clk_sys);
		check("ready delay", 16'(n >= lo && n <= hi), 16'h0001);
		tick(1);
	endtask
	task t_power_on;
		check("sensitive", 16'(glitch_det_en), 16'h0001);
		check("afc on", 16'(afc_en), 16'(AFC_CTRL_RST[0]));
		wait_ready(POR_T, POR_T + 10);
	endtask
	// held three cycles: the device filters single-cycle spikes on this input
	task glitch(input logic drop);
		vdd_glitch = 1'b1;
		tick(3);
		vdd_glitch = 1'b0;
		tick(6);
		check("glitch ready", 16'(dev_ready), 16'(!drop));
	endtask
	task t_normal_mode;
		glitch(1'b1);
		wait_ready(1, POR_T + 20);
		send(16'hca01);
		tick(6);
		check("normal mode", 16'(glitch_det_en), 16'h0000);
		glitch(1'b0);
	endtask
	task t_hw_reset;
		int n;
		req_hw_reset = 1'b1;
		tick(1);
		req_hw_reset = 1'b0;
		while (lnk.hw_reset_in_n !== 1'b0) @(negedge clk_sys);
		for (n = 0; lnk.hw_reset_in_n !== 1'b1; n++) begin
			@(negedge clk_sys);
			if (n == 8)
				check("held in reset", 16'(reset_active), 16'h0001);
		end
		check("pulse width", 16'(n >= HW_RST_MIN_CYC), 16'h0001);
		wait_ready(RDY_T, RDY_T + 10);
		check("mode reloaded", 16'(glitch_det_en), 16'h0001);
	endtask
	task t_sw_reset;
		send(16'hca01);
		tick(6);
		check("normal before sw", 16'(glitch_det_en), 16'h0000);
		// host pin and bench reset are separate nets, so a soft reset is safe here
		send(CMD_SW_RESET);
		wait_ready(POR_T, POR_T + 10);
		check("sw mode reload", 16'(glitch_det_en), 16'h0001);
	endtask
	task t_status;
		req_read_afc = 1'b1;
		tick(1);
		req_read_afc = 1'b0;
		check("host busy", 16'(busy), 16'h0001);
		for (int n = 0; afc_valid !== 1'b1 && n < 60; n++) @(negedge clk_sys);
		check("afc offset", 16'(afc_value), 16'(afc_offset));
		check("afc off", 16'(afc_en), 16'h0000);
		check("host idle", 16'(busy), 16'h0000);
	endtask
	initial begin
		tick(8);
		nrst = 1'b1;
		t_power_on();
		t_normal_mode();
		t_hw_reset();
		t_sw_reset();
		t_status();
		results();
	end
endmodule // tb
